// ### inc/xcpt_params.svh
`ifndef XCPT_PARAMS_SVH
`define XCPT_PARAMS_SVH
// Register map (byte addresses on the register bus)
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_INFO1_LO 12'h008
`define OFS_INFO1_HI 12'h00c
`define OFS_INFO2_LO 12'h010
`define OFS_INFO2_HI 12'h014
`define OFS_REASON 12'h018
`define OFS_PEND 12'h01c
`define OFS_EXCMASK 12'h020
// Control register fields
`define CTRL_SMM_LOCK 0
`define CTRL_MASKABLE_INTERRUPT_LINE_ICPT 1
`define CTRL_NMI_ICPT 2
`define CTRL_SMI_ICPT 3
// Exception vectors
`define VEC_DB 5'd1
`define VEC_NMI 5'd2
`define VEC_BP 5'd3
`define VEC_OF 5'd4
`define VEC_BR 5'd5
`define VEC_DF 5'd8
`define VEC_RSV9 5'd9
`define VEC_TS 5'd10
`define VEC_NP 5'd11
`define VEC_SS 5'd12
`define VEC_GP 5'd13
`define VEC_PF 5'd14
`define VEC_MF 5'd16
`define VEC_AC 5'd17
`define VEC_MC 5'd18
`define VEC_XF 5'd19
// Exit reason codes: exception reasons are base plus vector
`define RSN_EXC_BASE 12'h040
`define RSN_MASKABLE_INTERRUPT_LINE 12'h060
`define RSN_NMI 12'h061
`define RSN_SMI 12'h062
`define RSN_SHUTDOWN 12'h07f
// Breakpoint and overflow opcodes
`define OPC_BP 8'hcc
`define OPC_OF 8'hce
// Management exit word field positions
`define SMI_SRC_BIT 0
`define SMI_SEG_LSB 10
`define SMI_IO_LSB 32
`define SMI_VAL_BIT 33
`endif

// ### inc/xcpt_pkg.sv
package xcpt_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_EXIT = 2'b11
  } state_t;
  typedef enum logic [2:0] {
    EV_NONE = 3'd0,
    EV_EXC = 3'd1,
    EV_SWINT = 3'd2,
    EV_MASKABLE_INTERRUPT_LINE = 3'd3,
    EV_NMI = 3'd4,
    EV_SMI = 3'd5
  } ev_kind_t;
  // Event offered by the core pipeline
  typedef struct packed {
    logic valid;
    ev_kind_t kind;
    logic [4:0] vector;
    logic trap_type;
    logic single_byte_debug_trap;
    logic [7:0] opcode;
    logic [31:0] err_code;
    logic [63:0] fault_addr;
    logic [63:0] rip_cur;
    logic [63:0] rip_next;
    logic [15:0] cs_sel;
    logic side_fx_done;
    logic smi_ext;
    logic io_active;
    logic [31:0] io_info;
    logic [2:0] io_seg;
    logic exit_possible;
  } event_t;
  // Saved exit record
  typedef struct packed {
    logic [63:0] info1;
    logic [63:0] info2;
    logic [11:0] reason;
    logic [63:0] rip;
    logic [15:0] cs_sel;
  } exit_rec_t;
  typedef struct packed {
    logic [31:0] haddr;
    logic hwrite;
    logic sel;
  } ahb_cap_t;
  typedef struct packed {
    state_t st;
    event_t ev;
    exit_rec_t rec;
    ahb_cap_t cap;
    logic [31:0] hrdata;
    logic [31:0] excmask;
    logic [3:0] ctrl;
    logic exit_pulse;
    logic shutdown;
    logic ack;
    logic cr2_we;
    logic hold_pending;
    logic sti_shadow;
    logic exit_cnt_ovf;
    logic [15:0] exit_cnt;
  } state_all_t;
endpackage : xcpt_pkg

// ### rtl/xcpt_intercept.sv
// Overview of operation
// - Debug intercept: debug status/control already written; exit info undefined.
// - Fault debug saves causing pointer; trap debug saves next pointer.
// - Vector 1 from the one-byte debug trap never hits debug intercept.
// - Breakpoint trap from opcode cc saves that instruction's pointer.
// - Overflow trap from opcode ce intercepts; exit info undefined.
// - Bound-range fault intercepts; exit info undefined.
// - Double fault: pointer, exit info undefined; prior status already written.
// - Invalid task state: pointer is causing or incoming one.
// - Segment-absent, stack, alignment faults put error code in primary.
// - General protection fault puts error code in primary.
// - Page fault checked before fault address write; address in secondary.
// - Page fault primary holds protected-mode error code, even paged real.
// - Machine check exits when possible, else shuts down.
// - SIMD fault checked after SIMD status update.
// - Intercepted external interrupt exits and stays pending.
// - Exception bits never match external or software interrupts.
// - NMI and management interrupts held one instruction after flag set.
// - Primary bit 0 gives management interrupt source, 1 external.
// - Management interrupt during I/O sets valid, I/O detail, pointer.
// - Management exit word fields sit at fixed positions; reserved zero.
// - Management interrupt intercept ignored while lock bit set.
// - Exit reason encodes the exception vector recoverably.
`include "xcpt_params.svh"
module xcpt_intercept (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire xcpt_pkg::event_t EVENT_I,
  input wire logic INSTR_RETIRE_I,
  input wire logic STI_RETIRE_I,
  output logic EVENT_ACK_O,
  output logic GUEST_EXIT_O,
  output logic SHUTDOWN_O,
  output logic FAULT_ADDR_WE_O,
  output logic MASKABLE_INTERRUPT_LINE_PENDING_O,
  output xcpt_pkg::exit_rec_t EXIT_REC_O,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP
);
  import xcpt_pkg::*;

  state_all_t q, d;

  // Exception intercept match; only true exceptions look at the mask
  function automatic logic exc_hit(input event_t e, input logic [31:0] m);
    logic hit;
    hit = 1'b0;
    if (e.kind == EV_EXC) begin
      hit = m[e.vector];
      if (e.vector == `VEC_DB && e.single_byte_debug_trap)
        hit = 1'b0;
      if (e.vector == `VEC_BP && e.opcode != `OPC_BP)
        hit = 1'b0;
      if (e.vector == `VEC_OF && e.opcode != `OPC_OF)
        hit = 1'b0;
      // Unimplemented bits: treat as never matching
      if (e.vector == `VEC_NMI || e.vector == `VEC_RSV9)
        hit = 1'b0;
    end
    return hit;
  endfunction : exc_hit

  // Vectors that must finish their architectural side effects first
  function automatic logic needs_fx(input logic [4:0] v);
    return v == `VEC_DB || v == `VEC_DF || v == `VEC_MF ||
           v == `VEC_MC || v == `VEC_XF;
  endfunction : needs_fx

  // Build the exit record for a matched exception
  function automatic exit_rec_t exc_rec(input event_t e);
    exit_rec_t r;
    r = '0;
    r.reason = `RSN_EXC_BASE | {7'h00, e.vector};
    r.cs_sel = e.cs_sel;
    r.rip = e.rip_cur;
    case (e.vector)
      `VEC_DB: begin
        // Trap form points past the causing instruction
        r.rip = e.trap_type ? e.rip_next : e.rip_cur;
      end
      `VEC_BP, `VEC_OF, `VEC_BR: begin
        r.rip = e.rip_cur;
      end
      `VEC_DF, `VEC_TS: begin
        r.rip = e.rip_cur;
      end
      `VEC_NP, `VEC_SS, `VEC_AC, `VEC_GP: begin
        r.info1 = {32'h0, e.err_code};
      end
      `VEC_PF: begin
        r.info1 = {32'h0, e.err_code};
        r.info2 = e.fault_addr;
      end
      default: begin
        r.info1 = '0;
      end
    endcase
    return r;
  endfunction : exc_rec

  // Management interrupt exit word
  function automatic exit_rec_t smi_rec(input event_t e);
    exit_rec_t r;
    r = '0;
    r.reason = `RSN_SMI;
    r.cs_sel = e.cs_sel;
    r.rip = e.rip_cur;
    r.info1[`SMI_SRC_BIT] = e.smi_ext;
    if (e.io_active) begin
      r.info1[`SMI_IO_LSB +: 32] = e.io_info & 32'hffff_fbff;
      r.info1[`SMI_VAL_BIT] = 1'b1;
      r.info1[`SMI_SEG_LSB +: 3] = e.io_seg;
      r.info2 = e.rip_cur;
    end
    return r;
  endfunction : smi_rec

  // Next-state logic for intercept decision and register slave
  always_comb begin
    d = q;
    d.exit_pulse = 1'b0;
    d.ack = 1'b0;
    d.cr2_we = 1'b0;
    // Interrupt-flag set opens a one-instruction shadow
    if (STI_RETIRE_I)
      d.sti_shadow = 1'b1;
    else if (INSTR_RETIRE_I)
      d.sti_shadow = 1'b0;
    // Register writes come first, so a flag set below in the same cycle wins
    if (q.cap.sel && q.cap.hwrite) begin
      case (q.cap.haddr[11:0])
        `OFS_CTRL: d.ctrl = HWDATA[3:0];
        `OFS_EXCMASK: d.excmask = HWDATA;
        `OFS_STATUS: begin
          if (HWDATA[1])
            d.hold_pending = 1'b0; // Releases the held interrupt
          if (HWDATA[2])
            d.shutdown = 1'b0;
        end
        default: d.ctrl = d.ctrl;
      endcase
    end
    // Pending interrupt is released only when software clears it
    case (q.st)
      ST_IDLE: begin
        // A request still up while its ack shows is the old one, not a new one
        if (EVENT_I.valid && !q.ack) begin
          d.ev = EVENT_I;
          d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        d.st = ST_IDLE;
        d.ack = 1'b1;
        case (q.ev.kind)
          EV_EXC: begin
            if (exc_hit(q.ev, q.excmask)) begin
              if (!needs_fx(q.ev.vector) || q.ev.side_fx_done) begin
                d.rec = exc_rec(q.ev);
                d.st = ST_EXIT;
                if (q.ev.vector == `VEC_MC && !q.ev.exit_possible) begin
                  d.shutdown = 1'b1;
                  d.rec.reason = `RSN_SHUTDOWN;
                end
              end else begin
                d.st = ST_WAIT; // Wait for status writes
                d.ack = 1'b0;
                d.ev.side_fx_done = EVENT_I.side_fx_done;
              end
            end else if (q.ev.vector == `VEC_PF) begin
              d.cr2_we = 1'b1;
            end
          end
          EV_MASKABLE_INTERRUPT_LINE: begin
            if (q.ctrl[`CTRL_MASKABLE_INTERRUPT_LINE_ICPT]) begin
              d.rec = '0;
              d.rec.reason = `RSN_MASKABLE_INTERRUPT_LINE;
              d.rec.rip = q.ev.rip_cur;
              d.hold_pending = 1'b1;
              d.st = ST_EXIT;
            end
          end
          EV_NMI, EV_SMI: begin
            if (q.sti_shadow) begin
              d.st = ST_WAIT;
              d.ack = 1'b0;
            end else if (q.ev.kind == EV_NMI && q.ctrl[`CTRL_NMI_ICPT]) begin
              d.rec = '0;
              d.rec.reason = `RSN_NMI;
              d.rec.rip = q.ev.rip_cur;
              d.st = ST_EXIT;
            end else if (q.ev.kind == EV_SMI && q.ctrl[`CTRL_SMI_ICPT] &&
                         !q.ctrl[`CTRL_SMM_LOCK]) begin
              d.rec = smi_rec(q.ev);
              d.st = ST_EXIT;
            end
          end
          default: begin
            d.st = ST_IDLE; // Software interrupts never match
          end
        endcase
      end
      ST_EXIT: begin
        d.exit_pulse = 1'b1;
        d.st = ST_IDLE;
        if (q.exit_cnt == 16'hffff)
          d.exit_cnt_ovf = 1'b1;
        d.exit_cnt = q.exit_cnt + 16'h0001;
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // Bus slave: answers in the data phase with no wait states
    d.hrdata = '0;
    if (HSEL && HREADY && HTRANS[1]) begin
      d.cap.sel = 1'b1;
      d.cap.hwrite = HWRITE;
      d.cap.haddr = HADDR;
      if (!HWRITE) begin
        case (HADDR[11:0])
          `OFS_CTRL: d.hrdata = {28'h0, q.ctrl};
          `OFS_STATUS: d.hrdata = {q.exit_cnt, 12'h0, q.exit_cnt_ovf,
                                   q.shutdown, q.hold_pending,
                                   q.st != ST_IDLE};
          `OFS_INFO1_LO: d.hrdata = q.rec.info1[31:0];
          `OFS_INFO1_HI: d.hrdata = q.rec.info1[63:32];
          `OFS_INFO2_LO: d.hrdata = q.rec.info2[31:0];
          `OFS_INFO2_HI: d.hrdata = q.rec.info2[63:32];
          `OFS_REASON: d.hrdata = {20'h0, q.rec.reason};
          `OFS_PEND: d.hrdata = {16'h0, q.rec.cs_sel};
          `OFS_EXCMASK: d.hrdata = q.excmask;
          default: d.hrdata = '0; // Unmapped reads as zero
        endcase
      end
    end else if (HREADY) begin
      d.cap.sel = 1'b0;
    end
  end

  // State register
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I)
      q <= '0;
    else
      q <= d;
  end

  // Ports come straight from state flops, except HREADYOUT and HRESP, which are tied off
  assign EVENT_ACK_O = q.ack;
  assign GUEST_EXIT_O = q.exit_pulse;
  assign SHUTDOWN_O = q.shutdown;
  assign FAULT_ADDR_WE_O = q.cr2_we;
  assign MASKABLE_INTERRUPT_LINE_PENDING_O = q.hold_pending;
  assign EXIT_REC_O = q.rec;
  assign HRDATA = q.hrdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
endmodule : xcpt_intercept

// ### tb/xcpt_intercept_checker.sv
`include "xcpt_params.svh"
module xcpt_intercept_checker (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire logic EVENT_ACK_O,
  input wire logic GUEST_EXIT_O,
  input wire logic FAULT_ADDR_WE_O,
  input wire logic MASKABLE_INTERRUPT_LINE_PENDING_O,
  input wire xcpt_pkg::exit_rec_t EXIT_REC_O,
  input wire logic HREADYOUT,
  input wire logic HRESP
);
  import xcpt_pkg::*;
  // One clock domain, so one default clock and reset
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  a_exit_after_ack: assert property (
    GUEST_EXIT_O |-> $past(EVENT_ACK_O)) else $error("exit without ack");
  a_ack_one_cycle: assert property (
    EVENT_ACK_O |=> !EVENT_ACK_O) else $error("ack longer than one cycle");
  a_rec_before_exit: assert property (
    $changed(EXIT_REC_O) |-> ##1 GUEST_EXIT_O)
    else $error("record changed without exit");
  a_pf_no_write: assert property (
    GUEST_EXIT_O && EXIT_REC_O.reason == `RSN_EXC_BASE + `VEC_PF
    |-> !FAULT_ADDR_WE_O && !$past(FAULT_ADDR_WE_O))
    else $error("fault address written on intercept");
  a_mgmt_rsv_zero: assert property (
    GUEST_EXIT_O && EXIT_REC_O.reason == `RSN_SMI
    |-> EXIT_REC_O.info1[9:1] == 9'h0 && EXIT_REC_O.info1[31:13] == 19'h0
    && !EXIT_REC_O.info1[42]) else $error("reserved exit bits set");
  a_reason_known: assert property (
    GUEST_EXIT_O |-> EXIT_REC_O.reason inside {[12'h040:12'h05f],
    `RSN_MASKABLE_INTERRUPT_LINE, `RSN_NMI, `RSN_SMI, `RSN_SHUTDOWN})
    else $error("unknown exit reason");
  a_maskable_interrupt_line_held: assert property (
    GUEST_EXIT_O && EXIT_REC_O.reason == `RSN_MASKABLE_INTERRUPT_LINE |-> ##[0:1] MASKABLE_INTERRUPT_LINE_PENDING_O)
    else $error("interrupt not held pending");
  a_bus_okay: assert property (
    HREADYOUT && !HRESP) else $error("bus not ready or error");
endmodule : xcpt_intercept_checker

bind xcpt_intercept xcpt_intercept_checker i_chk (
  .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .EVENT_ACK_O(EVENT_ACK_O),
  .GUEST_EXIT_O(GUEST_EXIT_O), .FAULT_ADDR_WE_O(FAULT_ADDR_WE_O),
  .MASKABLE_INTERRUPT_LINE_PENDING_O(MASKABLE_INTERRUPT_LINE_PENDING_O), .EXIT_REC_O(EXIT_REC_O),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP));

// ### tb/xcpt_intercept_test.sv
`include "xcpt_params.svh"
`define CK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
  end end
module xcpt_intercept_test;
  timeunit 1ns;
  timeprecision 1ns;
  import xcpt_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, ret = 1'b0, interrupt_flag_set_instr = 1'b0;
  logic ack, gex, shut, we, pend, hsel, hwrite, hrdy, hresp;
  logic cr2_seen, ex;
  logic [1:0] htrans;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  event_t ev, b;
  exit_rec_t rec, r;
  int fail_count = 0, samples_checked = 0;

  xcpt_intercept i_dut (.SYS_CLK_I(clk), .ARST_N_I(arst_n), .EVENT_I(ev),
    .INSTR_RETIRE_I(ret), .STI_RETIRE_I(interrupt_flag_set_instr), .EVENT_ACK_O(ack),
    .GUEST_EXIT_O(gex), .SHUTDOWN_O(shut), .FAULT_ADDR_WE_O(we),
    .MASKABLE_INTERRUPT_LINE_PENDING_O(pend), .EXIT_REC_O(rec), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp));

  // Fault address strobe is a one-cycle pulse, so latch it
  always @(negedge clk) if (we === 1'b1) cr2_seen = 1'b1;

  task automatic conclude;
    $display("mismatches=%0d compares=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // Waits for the answer, sampled at the rising edge; read data taken there
  task automatic hold(input bit sel);
    int n;
    for (n = 0; n < 9; n++) begin
      @(posedge clk);
      if ((sel ? ack : hrdy) === 1'b1) break;
    end
    if (n == 9) begin fail_count++; conclude; end
    rdat = hrdata;
  endtask : hold

  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
    hold(0);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    hold(0);
  endtask : bus

  // Valid drops at the edge where ack is seen; exit stands one cycle later
  task automatic offer(input event_t e);
    ev <= e;
    hold(1);
    ev.valid <= 1'b0;
    @(posedge clk);
    ex = gex; r = rec;
  endtask : offer

  task automatic t_regs;
    bus(1, `OFS_EXCMASK, 32'hffff_fdfb);
    bus(0, `OFS_EXCMASK, 0); `CK(rdat, 32'hffff_fdfb)
    bus(0, 32'h40, 0); `CK(rdat, 32'h0)
    bus(1, `OFS_CTRL, 32'ha);
  endtask : t_regs

  task automatic t_vec;
    event_t e;
    logic [4:0] v[10] = '{`VEC_NP, `VEC_SS, `VEC_AC, `VEC_GP, `VEC_BR,
      `VEC_DF, `VEC_TS, `VEC_MF, `VEC_XF, `VEC_MC};
    foreach (v[i]) begin
      e = b; e.vector = v[i]; offer(e);
      `CK(ex, 1'b1)
      `CK(r.reason, `RSN_EXC_BASE + 12'(v[i]))
      if (i < 4) `CK(r.info1[31:0], 32'h5a)
    end
    e = b; e.vector = `VEC_PF; cr2_seen = 0; offer(e);
    `CK({ex, cr2_seen}, 2'b10)
    `CK(r.info2, 64'hdead0)
    `CK(r.info1[31:0], 32'h5a)
    bus(1, `OFS_EXCMASK, 32'hffff_bdfb); cr2_seen = 0; offer(e);
    `CK({ex, cr2_seen}, 2'b01)
  endtask : t_vec

  task automatic t_debug;
    event_t e;
    e = b; e.vector = `VEC_DB; e.trap_type = 1; offer(e);
    `CK(r.rip, 64'h1004)
    e.trap_type = 0; offer(e); `CK(r.rip, 64'h1000)
    e.single_byte_debug_trap = 1; offer(e); `CK(ex, 1'b0)
    e = b; e.vector = `VEC_BP; e.opcode = `OPC_BP; offer(e);
    `CK({ex, r.rip}, {1'b1, 64'h1000})
    e.vector = `VEC_OF; e.opcode = `OPC_OF; offer(e); `CK(ex, 1'b1)
  endtask : t_debug

  task automatic t_maskable_interrupt_line;
    event_t e;
    e = b; e.kind = EV_SWINT; offer(e); `CK(ex, 1'b0)
    e.kind = EV_MASKABLE_INTERRUPT_LINE; offer(e);
    `CK({ex, pend, r.reason}, {2'b11, `RSN_MASKABLE_INTERRUPT_LINE})
    bus(1, `OFS_STATUS, 32'h2); @(posedge clk); `CK(pend, 1'b0)
  endtask : t_maskable_interrupt_line

  task automatic t_mgmt;
    event_t e;
    e = b; e.kind = EV_SMI; e.smi_ext = 1; e.io_active = 1;
    e.io_info = 32'habcd_9001; e.io_seg = 3'd5; offer(e);
    `CK(r.info1[63:32], 32'habcd_9003)
    `CK({r.info1[12:10], r.info1[0]}, 4'hb)
    `CK({r.reason, r.info2}, {`RSN_SMI, 64'h1000})
    e.smi_ext = 0; e.io_active = 0; offer(e); `CK(r.info1[0], 1'b0)
    bus(1, `OFS_CTRL, 32'hb); offer(e); `CK(ex, 1'b0)
  endtask : t_mgmt

  // Held events: flag-set shadow, status not yet written; then machine check shutdown
  task automatic t_hold;
    event_t e;
    bus(1, `OFS_CTRL, 32'h4);
    e = b; e.kind = EV_NMI; interrupt_flag_set_instr <= 1'b1; ev <= e;
    @(posedge clk); interrupt_flag_set_instr <= 1'b0;
    repeat (4) @(posedge clk);
    `CK(ack, 1'b0)
    ret <= 1'b1; @(posedge clk); ret <= 1'b0;
    hold(1); ev.valid <= 1'b0; @(posedge clk);
    `CK({gex, rec.reason}, {1'b1, `RSN_NMI})
    e = b; e.vector = `VEC_MF; e.side_fx_done = 0; ev <= e;
    repeat (4) @(posedge clk);
    `CK(ack, 1'b0)
    ev.side_fx_done <= 1'b1; hold(1); ev.valid <= 1'b0; @(posedge clk);
    `CK(gex, 1'b1)
    e = b; e.vector = `VEC_MC; e.exit_possible = 0; offer(e);
    `CK({ex, shut, r.reason}, {2'b11, `RSN_SHUTDOWN})
    bus(1, `OFS_STATUS, 32'h4); @(posedge clk); `CK(shut, 1'b0)
  endtask : t_hold

  // Clock
  initial begin
    forever #25 clk = ~clk;
  end

  // Main sequence
  initial begin
    b = '0; b.valid = 1; b.kind = EV_EXC; b.side_fx_done = 1;
    b.exit_possible = 1; b.rip_cur = 64'h1000; b.rip_next = 64'h1004;
    b.err_code = 32'h5a; b.fault_addr = 64'hdead0; b.cs_sel = 16'h8;
    ev = '0; hsel = 0; htrans = 0; hwrite = 0; haddr = 0; hwdata = 0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_regs; t_vec; t_debug; t_maskable_interrupt_line; t_mgmt; t_hold;
    conclude;
  end
endmodule : xcpt_intercept_test
